// file: hw/dos_params.svh
// constants for the drive operating state machine: offsets, fields, resets, timing
// assumes inclusion by the state machine module and by the testbench
`ifndef DOS_PARAMS_SVH
`define DOS_PARAMS_SVH

// ==========================================================
// register indices on the 4-bit word address
`define DOS_OFF_CMD     4'h0
`define DOS_OFF_STATE   4'h1
`define DOS_OFF_CFG     4'h2
`define DOS_OFF_IRQSTAT 4'h3
`define DOS_OFF_IRQMASK 4'h4
`define DOS_OFF_ENV     4'h5

// ==========================================================
// command register fields (write-one pulses)
`define DOS_CMD_SHUTDOWN   0
`define DOS_CMD_SWITCHON   1
`define DOS_CMD_ENABLEOP   2
`define DOS_CMD_DISABLEOP  3
`define DOS_CMD_DISABLEV   4
`define DOS_CMD_AUTOTUNE   5
`define DOS_CMD_CFGWRITE   6
`define DOS_CMD_ADJWRITE   7

// config register fields
`define DOS_CFG_STOPSEL    0
`define DOS_CFG_SEPCTRL    1
`define DOS_CFG_ONECHAN    2
`define DOS_CFG_HALT       3

// status/mask bits
`define DOS_IRQ_STATECHG   0
`define DOS_IRQ_REJECT     1
`define DOS_IRQ_ERROR      2

// state word codes reported to the master
`define DOS_CODE_SWDIS     3'h2
`define DOS_CODE_READY     3'h3
`define DOS_CODE_SWON      3'h4
`define DOS_CODE_OPEN      3'h5

// ==========================================================
// reset values
`define DOS_CFG_RESET      4'h0
`define DOS_MASK_RESET     3'h0

// ==========================================================
// timing: initialization time and clock rate
`define DOS_INIT_NS        400
`define DOS_CLK_NS         4
`define DOS_INIT_CYC       ((`DOS_INIT_NS + `DOS_CLK_NS - 1) / `DOS_CLK_NS)

`endif

// file: hw/dos_pkg.sv
// types shared by the drive operating state machine
// assumes dos_params.svh holds the numeric constants
package dos_pkg;
  // ==========================================================
  // operating states
  typedef enum logic [2:0] {
    DOS_INIT,
    DOS_SW_DISABLED,
    DOS_READY,
    DOS_SWITCHED_ON,
    DOS_OP_ENABLED,
    DOS_RAMP_STOP
  } dos_state_e;
endpackage : dos_pkg

// file: hw/dos_sync.sv
// two-flop synchroniser for asynchronous pin levels, one per bit
// assumes a single clock and synchronous active-high reset
module dos_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // ==========================================================
  // synchroniser chain
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta    <= '0;
      syncOut <= '0;
    end else begin
      meta    <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule : dos_sync

// file: hw/drive_operating_state_machine.sv
// drive operating state machine with an avalon-mm register slave
// assumes pin inputs are asynchronous; one 250 MHz clock; synchronous reset
//
// Overview of operation
// - state changes only on a new command, the end of initialization, ramp done in ramp stop, or an internal error event
// - current state is readable in the drive state word at any time
// - after reset pass through hidden initialization state, never reported
// - switch on disabled: stage not ready, output locked, contactor open, params writable
// - ready: await supply, locked, contactor open; separate stage needs supply
// - switched on: stage on, contactor closed, output locked, adjustments allowed
// - configuration write while switched on returns to switch on disabled
// - operation enabled: output unlocked, adjustments allowed, configuration refused
// - operation enabled: no motor power with zero reference or halt
// - autotuning starts only in operation enabled, else rejected
// - enable operation acted on only while command channel is valid
// - single channel needs reference received once before enable operation
// - disable operation with stop select 0: immediate switched on, freewheel
// - disable operation with stop select 1: ramp stop, then switched on

`include "dos_params.svh"

module drive_operating_state_machine
  import dos_pkg::*;
#(
  parameter int INIT_CYCLES = `DOS_INIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        powerSupplyOk,
  input  wire logic        chanValid,
  input  wire logic        refReceived,
  input  wire logic        refZero,
  input  wire logic        errorDetected,
  input  wire logic        rampDone,
  output logic             powerStageReady,
  output logic             contactorClose,
  output logic             outputUnlock,
  output logic             motorPower,
  output logic             freewheel,
  output logic             rampStop,
  output logic             autotuneStart,
  output logic             cfgWriteAccept,
  output logic             adjWriteAccept,
  output logic             irq
);
  import dos_pkg::*;

  // ==========================================================
  // pin synchronisation
  // every pin is taken as asynchronous: two flops add two cycles of reaction
  // time, a small price against a metastable value reaching the state decode
  logic [5:0] pinSync;

  dos_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk    (clk),
    .srst   (srst),
    .asyncIn({rampDone, errorDetected, refZero, refReceived, chanValid, powerSupplyOk}),
    .syncOut(pinSync)
  );

  wire supplyOk = pinSync[0];
  wire chanOk   = pinSync[1];
  wire refSeen  = pinSync[2];
  wire refIsZero = pinSync[3];
  wire errorIn  = pinSync[4];
  wire rampIn   = pinSync[5];

  // ==========================================================
  // register map, one 32-bit word per index of the 4-bit address:
  //   0 command, write-one pulses, reads zero
  //   1 drive_state_word, read-only state code
  //   2 configuration: stop select, separate stage, one channel, halt
  //   3 event status, sticky, cleared by the read that returns it
  //   4 event mask, same layout as the status
  //   5 synchronised pin levels, read-only
  // other indices read zero and ignore writes

  // ==========================================================
  // bus decode: one wait cycle per access, then the answer
  logic        busy;
  logic [3:0]  cfg;
  logic [2:0]  irqStat;
  logic [2:0]  irqMask;
  logic [2:0]  stateCode;
  dos_state_e  state;
  dos_state_e  next_state;
  logic [$clog2(INIT_CYCLES+1)-1:0] initCnt;

  // initialization ends when the countdown has run out; it never reloads
  // outside reset, so a long run cannot drop back into the hidden state
  wire initDone = (initCnt == '0);

  wire access    = (read | write) & ~busy;
  wire wrStrobe  = write & busy;
  wire rdStrobe  = read & busy;
  wire hitCmd    = (address == `DOS_OFF_CMD);
  wire hitState  = (address == `DOS_OFF_STATE);
  wire hitCfg    = (address == `DOS_OFF_CFG);
  wire hitStat   = (address == `DOS_OFF_IRQSTAT);
  wire hitMask   = (address == `DOS_OFF_IRQMASK);
  wire hitEnv    = (address == `DOS_OFF_ENV);

  // command pulses, only valid on the accepted write edge
  wire [7:0] cmd = (wrStrobe & hitCmd) ? writedata[7:0] : 8'h00;
  wire cShutdown = cmd[`DOS_CMD_SHUTDOWN];
  wire cSwitchOn = cmd[`DOS_CMD_SWITCHON];
  wire cEnableOp = cmd[`DOS_CMD_ENABLEOP];
  wire cDisOp    = cmd[`DOS_CMD_DISABLEOP];
  wire cDisV     = cmd[`DOS_CMD_DISABLEV];
  wire cAutotune = cmd[`DOS_CMD_AUTOTUNE];
  wire cCfgWr    = cmd[`DOS_CMD_CFGWRITE];
  wire cAdjWr    = cmd[`DOS_CMD_ADJWRITE];

  wire stopSel   = cfg[`DOS_CFG_STOPSEL];
  wire sepCtrl   = cfg[`DOS_CFG_SEPCTRL];
  wire oneChan   = cfg[`DOS_CFG_ONECHAN];
  wire haltCmd   = cfg[`DOS_CFG_HALT];

  // ==========================================================
  // state permissions
  // ramp stop still counts as operation enabled towards the master, so it
  // shares the adjustment permission and refuses configuration like state 5
  wire inOp     = (state == DOS_OP_ENABLED);
  wire inSwOn   = (state == DOS_SWITCHED_ON);
  wire cfgAllow = (state == DOS_SW_DISABLED) | (state == DOS_READY) | inSwOn;
  wire adjAllow = cfgAllow | inOp | (state == DOS_RAMP_STOP);
  wire enableOk = chanOk & (~oneChan | refSeen);
  wire supplyGo = ~sepCtrl | supplyOk;
  wire tuneOk   = cAutotune & inOp;
  wire tuneRej  = cAutotune & ~inOp;

  // ==========================================================
  // next state: only commands, the end of initialization, ramp done or the error event move it
  // a command that is not legal in the current state leaves the state alone
  always_comb begin
    next_state = state;
    case (state)
      DOS_INIT: begin
        if (initDone) next_state = DOS_SW_DISABLED;
      end
      DOS_SW_DISABLED: begin
        if (cShutdown) next_state = DOS_READY;
      end
      DOS_READY: begin
        if (cDisV) next_state = DOS_SW_DISABLED;
        else if (cSwitchOn && supplyGo) next_state = DOS_SWITCHED_ON;
      end
      DOS_SWITCHED_ON: begin
        if (cDisV || cCfgWr) next_state = DOS_SW_DISABLED;
        else if (cShutdown) next_state = DOS_READY;
        else if (cEnableOp && enableOk) next_state = DOS_OP_ENABLED;
      end
      DOS_OP_ENABLED: begin
        if (cDisV) next_state = DOS_SW_DISABLED;
        else if (cShutdown) next_state = DOS_READY;
        else if (cDisOp && !stopSel) next_state = DOS_SWITCHED_ON;
        else if (cDisOp && stopSel) next_state = DOS_RAMP_STOP;
      end
      DOS_RAMP_STOP: begin
        if (cDisV) next_state = DOS_SW_DISABLED;
        else if (rampIn) next_state = DOS_SWITCHED_ON;
      end
      default: next_state = DOS_INIT;
    endcase
    // a detected error drops the drive to a safe locked state
    if (errorIn && state != DOS_INIT) next_state = DOS_SW_DISABLED;
  end

  // ==========================================================
  // reported code: ramp stop still counts as operation enabled
  always_comb begin
    case (state)
      DOS_SW_DISABLED: stateCode = `DOS_CODE_SWDIS;
      DOS_READY:       stateCode = `DOS_CODE_READY;
      DOS_SWITCHED_ON: stateCode = `DOS_CODE_SWON;
      DOS_OP_ENABLED:  stateCode = `DOS_CODE_OPEN;
      DOS_RAMP_STOP:   stateCode = `DOS_CODE_OPEN;
      default:         stateCode = `DOS_CODE_SWDIS;
    endcase
  end

  // ==========================================================
  // output decode from the next state, so every output moves on the same
  // edge as the state register and leaves the flop directly
  wire nextIsOp   = (next_state == DOS_OP_ENABLED);
  wire nextIsRamp = (next_state == DOS_RAMP_STOP);
  wire nextIsSwOn = (next_state == DOS_SWITCHED_ON);
  wire nextRun    = nextIsOp | nextIsRamp;
  wire nextParked = (next_state == DOS_INIT) | (next_state == DOS_SW_DISABLED);

  wire next_powerStageReady = ~nextParked;
  wire next_contactorClose  = nextIsSwOn | nextRun;
  wire next_outputUnlock    = nextRun;
  // the ramp needs the motor fed until it ends, whatever the reference
  wire next_motorPower      = (nextIsOp & ~refIsZero & ~haltCmd) | nextIsRamp;
  wire next_freewheel       = ~nextRun;
  wire next_rampStop        = nextIsRamp;
  // a start is only given when the drive also stays in state 5
  wire next_autotuneStart   = tuneOk & nextIsOp;
  wire next_cfgWriteAccept  = cCfgWr & cfgAllow;
  wire next_adjWriteAccept  = cAdjWr & adjAllow;

  // ==========================================================
  // events for the sticky status bits
  wire stateChg = (next_state != state) && (state != DOS_INIT);
  wire tuneLost = tuneOk & ~nextIsOp;
  wire [2:0] events = {errorIn, tuneRej | tuneLost | (cCfgWr & ~cfgAllow), stateChg};
  wire statRead = rdStrobe & hitStat;

  // a status read clears only the bits that it returned; an event that
  // lands in the same cycle, or after the data was taken, stays set
  wire [2:0] readClear = statRead ? readdata[2:0] : 3'h0;
  wire [2:0] next_irqStat;

  for (genvar b = 0; b < 3; b++) begin : g_stat
    assign next_irqStat[b] = (irqStat[b] & ~readClear[b]) | events[b];
  end

  wire next_irq = |(next_irqStat & irqMask);

  // ==========================================================
  // state register and initialization counter
  always_ff @(posedge clk) begin
    if (srst) begin
      state   <= DOS_INIT;
      initCnt <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1);
    end else begin
      state   <= next_state;
      if (!initDone) initCnt <= initCnt - 1'b1;
    end
  end

  // ==========================================================
  // drive outputs, all registered
  // every output leaves a flop, so the pins never glitch while the
  // next-state decode settles
  always_ff @(posedge clk) begin
    if (srst) begin
      powerStageReady <= 1'b0;
      contactorClose  <= 1'b0;
      outputUnlock    <= 1'b0;
      motorPower      <= 1'b0;
      freewheel       <= 1'b1;
      rampStop        <= 1'b0;
      autotuneStart   <= 1'b0;
      cfgWriteAccept  <= 1'b0;
      adjWriteAccept  <= 1'b0;
    end else begin
      powerStageReady <= next_powerStageReady;
      contactorClose  <= next_contactorClose;
      outputUnlock    <= next_outputUnlock;
      motorPower      <= next_motorPower;
      freewheel       <= next_freewheel;
      rampStop        <= next_rampStop;
      autotuneStart   <= next_autotuneStart;
      cfgWriteAccept  <= next_cfgWriteAccept;
      adjWriteAccept  <= next_adjWriteAccept;
    end
  end

  // ==========================================================
  // software registers and interrupt status; set wins over read-clear
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg     <= `DOS_CFG_RESET;
      irqMask <= `DOS_MASK_RESET;
      irqStat <= 3'h0;
      irq     <= 1'b0;
    end else begin
      if (wrStrobe && hitCfg) cfg <= writedata[3:0];
      if (wrStrobe && hitMask) irqMask <= writedata[2:0];
      irqStat <= next_irqStat;
      irq     <= next_irq;
    end
  end

  // ==========================================================
  // avalon response: waitrequest high on the first cycle of each access
  // fixed latency keeps the decode trivial; the price is one idle cycle
  // between accesses, since busy blocks a new request on the answer edge
  wire [31:0] rdMux = hitState ? {29'h0, stateCode} :
                      hitCfg   ? {28'h0, cfg} :
                      hitStat  ? {29'h0, irqStat} :
                      hitMask  ? {29'h0, irqMask} :
                      hitEnv   ? {26'h0, pinSync} : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      busy        <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      busy        <= access;
      waitrequest <= ~access;
      if (access && read) readdata <= rdMux;
    end
  end
endmodule : drive_operating_state_machine

// file: test/dos_bus_master.sv
// fieldbus master model speaking avalon-mm to the register slave
// assumes the bench calls xfer and bounds every wait with its watchdog
module dos_bus_master (
  input  wire logic        clk,
  output logic      [3:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // idle bus, then one request held until waitrequest is low
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
endmodule : dos_bus_master

// file: test/dos_monitor.sv
// checker for the drive operating state machine ports
// assumes binding to the top module; one clock, sync reset
module dos_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic refZero,
  input wire logic contactorClose,
  input wire logic outputUnlock,
  input wire logic motorPower,
  input wire logic freewheel,
  input wire logic rampStop,
  input wire logic autotuneStart,
  input wire logic cfgWriteAccept
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // bus answers and output relations
  sequence s_one_wait;
    !waitrequest ##1 waitrequest;
  endsequence
  // pins pass two sync flops, so allow a few cycles
  sequence s_zero_held;
    refZero [*5];
  endsequence
  a_read_answer: assert property ($rose(read) |=> s_one_wait)
    else $error("read answer not one wait state");
  a_write_taken: assert property ($rose(write) |=> s_one_wait)
    else $error("write answer not one wait state");
  a_lock_nopower: assert property (!outputUnlock |-> !motorPower)
    else $error("motor powered while locked");
  a_zero_ref: assert property (s_zero_held |-> !motorPower)
    else $error("motor powered with zero reference");
  a_unlock_closed: assert property (outputUnlock |-> contactorClose)
    else $error("output unlocked with contactor open");
  a_tune_running: assert property (autotuneStart |-> outputUnlock)
    else $error("autotune started outside operation");
  a_cfg_refused: assert property (cfgWriteAccept |-> !outputUnlock)
    else $error("configuration accepted while running");
  a_ramp_driven: assert property (rampStop |-> !freewheel)
    else $error("freewheel during ramp stop");
  a_reset_idle: assert property ($fell(srst) |-> freewheel && !contactorClose)
    else $error("outputs not idle after reset");
endmodule : dos_monitor

bind drive_operating_state_machine dos_monitor i_mon (
  .clk(clk), .srst(srst), .read(read), .write(write), .waitrequest(waitrequest),
  .refZero(refZero), .contactorClose(contactorClose), .outputUnlock(outputUnlock),
  .motorPower(motorPower), .freewheel(freewheel), .rampStop(rampStop),
  .autotuneStart(autotuneStart), .cfgWriteAccept(cfgWriteAccept)
);

// file: test/testbench.sv
// self-checking bench for the drive operating state machine
// assumes dos_params.svh offsets; short init count of 4 cycles
`include "dos_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dos_pkg::*;
  typedef struct packed {
    logic [3:0] cfg;
    logic [5:0] pins;
    logic [7:0] cmd;
    logic [2:0] code;
  } dos_row_s;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  pins = 6'h00;
  logic [3:0]  address, curCfg;
  logic        read, write, waitrequest, irq;
  logic [31:0] writedata, readdata, q;
  logic        contactorClose, outputUnlock, motorPower, freewheel, rampStop;
  logic        powerStageReady, cfgWriteAccept, adjWriteAccept;
  int          n_fail = 0;
  int          n_checks = 0;
  // pins: {ramp, err, refZero, refRx, chan, supply}; master sends reference first
  dos_row_s rows [22] = '{
    '{4'h4, 6'h03, 8'h01, 3'h3}, '{4'h4, 6'h00, 8'h00, 3'h3}, '{4'h4, 6'h03, 8'h02, 3'h4},
    '{4'h4, 6'h03, 8'h20, 3'h4}, '{4'h4, 6'h03, 8'h04, 3'h4}, '{4'h4, 6'h05, 8'h04, 3'h4},
    '{4'h4, 6'h07, 8'h04, 3'h5}, '{4'h4, 6'h0f, 8'h00, 3'h5}, '{4'h4, 6'h07, 8'h20, 3'h5},
    '{4'h4, 6'h07, 8'h40, 3'h5}, '{4'h4, 6'h07, 8'h08, 3'h4}, '{4'h4, 6'h07, 8'h40, 3'h2},
    '{4'h6, 6'h06, 8'h01, 3'h3}, '{4'h6, 6'h06, 8'h02, 3'h3}, '{4'h6, 6'h07, 8'h02, 3'h4},
    '{4'h6, 6'h07, 8'h10, 3'h2}, '{4'h1, 6'h07, 8'h01, 3'h3}, '{4'h1, 6'h07, 8'h02, 3'h4},
    '{4'h1, 6'h07, 8'h04, 3'h5}, '{4'h1, 6'h07, 8'h08, 3'h5}, '{4'h1, 6'h27, 8'h00, 3'h4},
    '{4'h1, 6'h17, 8'h04, 3'h2}};
  always #2 clk = ~clk;
  drive_operating_state_machine #(.INIT_CYCLES(4)) i_dut (
    .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .powerSupplyOk(pins[0]), .chanValid(pins[1]), .refReceived(pins[2]),
    .refZero(pins[3]), .errorDetected(pins[4]), .rampDone(pins[5]),
    .powerStageReady(powerStageReady), .contactorClose(contactorClose),
    .outputUnlock(outputUnlock), .motorPower(motorPower), .freewheel(freewheel),
    .rampStop(rampStop), .autotuneStart(), .cfgWriteAccept(cfgWriteAccept),
    .adjWriteAccept(adjWriteAccept), .irq(irq));
  dos_bus_master i_master (
    .clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  // ==========================================================
  // comparison, bus shorthands and verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_master.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    i_master.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // watchdog: the whole run needs well under 4000 cycles
  initial begin
    #16000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(`DOS_OFF_STATE);
    check("init code", q, 32'h2);
    repeat (8) @(posedge clk);
    rd(`DOS_OFF_STATE);
    check("auto start", q, 32'h2);
    curCfg = 4'h0;
    // cfg rewritten only from states 2 or 3, never as a stray modification
    foreach (rows[i]) begin
      if (rows[i].cfg !== curCfg) wr(`DOS_OFF_CFG, {28'h0, rows[i].cfg});
      curCfg = rows[i].cfg;
      pins <= rows[i].pins;
      repeat (4) @(posedge clk);
      if (rows[i].cmd !== 8'h00) wr(`DOS_OFF_CMD, {24'h0, rows[i].cmd});
      rd(`DOS_OFF_STATE);
      check("state", q, {29'h0, rows[i].code});
      check("unlock", outputUnlock, rows[i].code == 3'h5);
      check("contactor", contactorClose, rows[i].code >= 3'h4);
      check("stage", powerStageReady, rows[i].code >= 3'h3);
      check("power", motorPower, rows[i].code == 3'h5 && !rows[i].pins[3]);
    end
    // rejected autotune in state 2 raises the masked interrupt
    pins <= 6'h07;
    rd(`DOS_OFF_IRQMASK);
    check("mask reset", q, 32'h0);
    // the rows left state changes, rejects and an error behind: read them off
    rd(`DOS_OFF_IRQSTAT);
    check("event flags", q, 32'h7);
    wr(`DOS_OFF_IRQMASK, 32'h2);
    check("irq idle", irq, 1'b0);
    wr(`DOS_OFF_CMD, 32'h20);
    repeat (3) @(posedge clk);
    check("irq", irq, 1'b1);
    rd(`DOS_OFF_IRQSTAT);
    check("reject flag", q[1], 1'b1);
    rd(`DOS_OFF_IRQSTAT);
    check("flag cleared", q[1], 1'b0);
    check("irq low", irq, 1'b0);
    // switch on disabled takes both configuration and adjustment writes
    wr(`DOS_OFF_CMD, 32'hc0);
    @(negedge clk);
    check("cfg accept", cfgWriteAccept, 1'b1);
    check("adj accept", adjWriteAccept, 1'b1);
    rd(4'h9);
    check("unmapped", q, 32'h0);
    // second reset in mid-run
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(`DOS_OFF_STATE);
    check("reinit code", q, 32'h2);
    check("reinit lock", outputUnlock, 1'b0);
    final_report();
  end
endmodule : testbench
